/* File: tlc_alert_core.sv */
// module: limit registers, temperature formatting and alert pin logic behind wishbone
`timescale 1ns/1ns
module tlc_alert_core
    import tlc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sample_valid_i,
    input  wire logic [12:0] sample_data_i,
    output logic             conv_run_o,
    output logic             alert_o,
    output logic             alert_oe_n_o
);

    // limit index order in the limit array
    localparam int unsigned LIM_UP = 0;
    localparam int unsigned LIM_LO = 1;
    localparam int unsigned LIM_CR = 2;
    localparam logic [7:0]  LIM_ADR [TLC_NUM_LIM] = '{TLC_ADR_UPPER, TLC_ADR_LOWER, TLC_ADR_CRIT};

    logic        ack_ff;
    logic [31:0] rdat_ff;
    logic        mode_ff;
    logic        pol_ff;
    logic        crit_only_ff;
    logic        out_en_ff;
    logic        sensor_shutdown_ff;
    logic [1:0]  hys_ff;
    logic [1:0]  res_ff;
    logic [10:0] lim_ff [TLC_NUM_LIM];
    logic [12:0] temp_ff;
    logic        hi_st_ff;
    logic        lo_st_ff;
    logic        crit_st_ff;
    logic        event_ff;
    logic        clr_pend_ff;
    logic        active_ff;
    logic        oe_n_ff;

    logic        wb_req;
    logic        wr_go;
    logic [31:0] rd_word;
    logic        crit_hit;
    logic        hi_hit;
    logic        lo_hit;
    logic        nxt_hi_st;
    logic        nxt_lo_st;
    logic        nxt_crit_st;
    logic        ev_set;
    logic        clr_req;
    logic        alert_level;
    logic [13:0] hyst;

    // limit widened to reading format: two zero fraction bits appended
    function automatic logic [12:0] lim_ext(input logic [10:0] lim);
        return {lim, 2'b00};
    endfunction : lim_ext

    // keep only the bits the selected resolution supports
    function automatic logic [12:0] res_mask(input logic [1:0] res);
        unique case (res)
            2'h0:    return 13'h1FF8;
            2'h1:    return 13'h1FFC;
            2'h2:    return 13'h1FFE;
            default: return 13'h1FFF;
        endcase
    endfunction : res_mask

    // classic wishbone: one wait state, ack drops in the cycle after it was given
    assign wb_req   = wb_cyc_i & wb_stb_i;
    assign wr_go    = wb_req & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= wb_req & ~ack_ff;
    end

    // read data captured in the wait state; unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_ff <= TLC_RDAT_RST;
        else if (wb_req & ~ack_ff & ~wb_we_i)
            rdat_ff <= rd_word;
    end

    // configuration fields; the clear bit is an action, never stored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_ff      <= 1'b0;
            pol_ff       <= 1'b0;
            crit_only_ff <= 1'b0;
            out_en_ff    <= 1'b0;
            sensor_shutdown_ff      <= 1'b0;
            hys_ff       <= TLC_HYS_RST;
        end
        else if (wr_go && wb_adr_i == TLC_ADR_CFG)
        begin
            if (wb_sel_i[0])
            begin
                mode_ff      <= wb_dat_i[TLC_CFG_MODE];
                pol_ff       <= wb_dat_i[TLC_CFG_POL];
                crit_only_ff <= wb_dat_i[TLC_CFG_CRITONLY];
                out_en_ff    <= wb_dat_i[TLC_CFG_OUTEN];
            end
            if (wb_sel_i[1])
            begin
                sensor_shutdown_ff <= wb_dat_i[TLC_CFG_SENSOR_SHUTDOWN];
                hys_ff  <= wb_dat_i[TLC_CFG_HYS_HI:TLC_CFG_HYS_LO];
            end
        end
    end

    // resolution selector, steers masking of the reading
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            res_ff <= TLC_RES_RST;
        else if (wr_go && wb_adr_i == TLC_ADR_RES && wb_sel_i[0])
            res_ff <= wb_dat_i[1:0];
    end

    // limits accept writes at any moment, even in shutdown
    for (genvar g = 0; g < TLC_NUM_LIM; g++)
    begin : g_lim
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                lim_ff[g] <= TLC_LIM_RST;
            else if (wr_go && wb_adr_i == LIM_ADR[g])
            begin
                if (wb_sel_i[0])
                    lim_ff[g][5:0] <= wb_dat_i[7:TLC_LIM_LSB];
                if (wb_sel_i[1])
                    lim_ff[g][10:6] <= wb_dat_i[TLC_LIM_MSB:8];
            end
        end
    end

    // reading follows the converter only while running
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            temp_ff <= TLC_TEMP_RST;
        else if (sample_valid_i & ~sensor_shutdown_ff)
            temp_ff <= sample_data_i;
    end

    assign conv_run_o = ~sensor_shutdown_ff;

    // raw comparisons straight from the registers, so limit writes act at once
    assign crit_hit = $signed(temp_ff) >= $signed(lim_ext(lim_ff[LIM_CR]));
    assign hi_hit   = $signed(temp_ff) >  $signed(lim_ext(lim_ff[LIM_UP]));
    assign lo_hit   = $signed(temp_ff) <  $signed(lim_ext(lim_ff[LIM_LO]));

    // hysteresis offset in reading lsbs
    always_comb
    begin
        unique case (tlc_hys_t'(hys_ff))
            TLC_HYS_OFF: hyst = 14'h0000;
            TLC_HYS_1P5: hyst = TLC_HYS_CNT_1P5;
            TLC_HYS_3:   hyst = TLC_HYS_CNT_3;
            TLC_HYS_6:   hyst = TLC_HYS_CNT_6;
        endcase
    end

    // trip states: set on the raw limit, released only past limit minus offset, or limit plus offset for the low limit;
    // widened to 14 bits so the offset can not wrap near the range ends
    always_comb
    begin
        logic signed [13:0] t14;
        logic signed [13:0] hi_rel;
        logic signed [13:0] lo_rel;
        logic signed [13:0] cr_rel;
        t14    = {temp_ff[12], temp_ff};
        hi_rel = $signed({lim_ff[LIM_UP][10], lim_ff[LIM_UP], 2'b00}) - $signed(hyst);
        lo_rel = $signed({lim_ff[LIM_LO][10], lim_ff[LIM_LO], 2'b00}) + $signed(hyst);
        cr_rel = $signed({lim_ff[LIM_CR][10], lim_ff[LIM_CR], 2'b00}) - $signed(hyst);
        nxt_hi_st   = hi_hit   | (hi_st_ff   & (t14 >  hi_rel));
        nxt_lo_st   = lo_hit   | (lo_st_ff   & (t14 <  lo_rel));
        nxt_crit_st = crit_hit | (crit_st_ff & (t14 >= cr_rel));
    end

    // trip states freeze during shutdown so the alert keeps its last level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hi_st_ff   <= 1'b0;
            lo_st_ff   <= 1'b0;
            crit_st_ff <= 1'b0;
        end
        else if (!sensor_shutdown_ff)
        begin
            hi_st_ff   <= nxt_hi_st;
            lo_st_ff   <= nxt_lo_st;
            crit_st_ff <= nxt_crit_st;
        end
    end

    // any crossing, in or out, of an enabled upper or lower limit records an event; the critical limit only on the way in
    assign ev_set  = mode_ff & ~sensor_shutdown_ff &
                     ((~crit_only_ff & ((nxt_hi_st ^ hi_st_ff) | (nxt_lo_st ^ lo_st_ff))) |
                      (nxt_crit_st & ~crit_st_ff));
    assign clr_req = wr_go & (wb_adr_i == TLC_ADR_CFG) & wb_sel_i[0] &
                     wb_dat_i[TLC_CFG_CLEAR] & mode_ff;

    // recorded event: a new crossing wins over a clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            event_ff <= 1'b0;
        else if (ev_set)
            event_ff <= 1'b1;
        else if ((clr_req | clr_pend_ff) & ~crit_st_ff)
            event_ff <= 1'b0;
    end

    // clear taken above critical is acknowledged and held until temperature falls
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            clr_pend_ff <= 1'b0;
        else if (!mode_ff || !crit_st_ff)
            clr_pend_ff <= 1'b0;
        else if (clr_req)
            clr_pend_ff <= 1'b1;
    end

    // alert level per mode; critical state alone keeps it up in interrupt mode
    always_comb
    begin
        if (mode_ff)
            alert_level = event_ff | crit_st_ff;
        else if (crit_only_ff)
            alert_level = crit_st_ff;
        else
            alert_level = hi_st_ff | lo_st_ff | crit_st_ff;
    end

    // open-drain pin: pulled low when asserted active-low or idle active-high;
    // a disabled output with active-high polarity is therefore held grounded
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            active_ff <= 1'b0;
            oe_n_ff   <= 1'b1;
        end
        else
        begin
            active_ff <= out_en_ff & alert_level;
            oe_n_ff   <= ~(pol_ff ^ (out_en_ff & alert_level));
        end
    end

    assign alert_o      = 1'b0;         // open drain only ever pulls low
    assign alert_oe_n_o = oe_n_ff;

    // register read mux; reserved bits read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            TLC_ADR_CFG:
            begin
                rd_word[TLC_CFG_MODE]                 = mode_ff;
                rd_word[TLC_CFG_POL]                  = pol_ff;
                rd_word[TLC_CFG_CRITONLY]             = crit_only_ff;
                rd_word[TLC_CFG_OUTEN]                = out_en_ff;
                rd_word[TLC_CFG_STS]                  = active_ff;
                rd_word[TLC_CFG_SENSOR_SHUTDOWN]                 = sensor_shutdown_ff;
                rd_word[TLC_CFG_HYS_HI:TLC_CFG_HYS_LO] = hys_ff;
            end
            TLC_ADR_UPPER: rd_word[12:0] = lim_ext(lim_ff[LIM_UP]);
            TLC_ADR_LOWER: rd_word[12:0] = lim_ext(lim_ff[LIM_LO]);
            TLC_ADR_CRIT:  rd_word[12:0] = lim_ext(lim_ff[LIM_CR]);
            TLC_ADR_TEMP:
            begin
                rd_word[TLC_TMP_CRIT] = crit_hit;
                rd_word[TLC_TMP_HIGH] = hi_hit;
                rd_word[TLC_TMP_LOW]  = lo_hit;
                rd_word[12:0]         = temp_ff & res_mask(res_ff);
            end
            TLC_ADR_RES:   rd_word[1:0] = res_ff;
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    // checks

    sequence s_temp_read;
        wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == TLC_ADR_TEMP;
    endsequence

    sequence s_lim_read;
        wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i &&
        (wb_adr_i == TLC_ADR_UPPER || wb_adr_i == TLC_ADR_LOWER || wb_adr_i == TLC_ADR_CRIT);
    endsequence

    property p_flags_read;
        @(posedge clk_i) disable iff (rst_i)
        s_temp_read |-> wb_dat_o[15:13] == $past({crit_hit, hi_hit, lo_hit});
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("reading flags wrong");

    property p_lim_zero_bits;
        @(posedge clk_i) disable iff (rst_i)
        s_lim_read |-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[1:0] == 2'h0;
    endproperty
    a_lim_zero_bits: assert property (p_lim_zero_bits) else $error("limit pad bits set");

    property p_res_mask;
        @(posedge clk_i) disable iff (rst_i)
        s_temp_read and $past(res_ff) == 2'h0 |-> wb_dat_o[2:0] == 3'h0;
    endproperty
    a_res_mask: assert property (p_res_mask) else $error("unsupported bits not zero");

    property p_cross_event;
        @(posedge clk_i) disable iff (rst_i)
        mode_ff && !sensor_shutdown_ff && !crit_only_ff && (nxt_hi_st != hi_st_ff) |=> event_ff;
    endproperty
    a_cross_event: assert property (p_cross_event) else $error("crossing lost");

    property p_clear_done;
        @(posedge clk_i) disable iff (rst_i)
        clr_req && !crit_st_ff && !ev_set |=> !event_ff ##1 (alert_level == crit_st_ff);
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("clear not applied");

    property p_crit_hold;
        @(posedge clk_i) disable iff (rst_i)
        mode_ff && crit_st_ff && event_ff && !sensor_shutdown_ff |=> event_ff;
    endproperty
    a_crit_hold: assert property (p_crit_hold) else $error("event cleared above critical");

    property p_pend_exec;
        @(posedge clk_i) disable iff (rst_i)
        clr_pend_ff && mode_ff && !crit_st_ff && !ev_set |=> !event_ff && !clr_pend_ff;
    endproperty
    a_pend_exec: assert property (p_pend_exec) else $error("pending clear not run");

    property p_cmp_ignore;
        @(posedge clk_i) disable iff (rst_i)
        !mode_ff |=> !clr_pend_ff;
    endproperty
    a_cmp_ignore: assert property (p_cmp_ignore) else $error("clear seen in comparator");

    property p_cmp_window;
        @(posedge clk_i) disable iff (rst_i)
        !mode_ff && !crit_only_ff && out_en_ff && (hi_st_ff || lo_st_ff) ##1
        $stable(mode_ff) && $stable(out_en_ff) |-> active_ff;
    endproperty
    a_cmp_window: assert property (p_cmp_window) else $error("window alert missing");

    property p_sensor_shutdown_freeze;
        @(posedge clk_i) disable iff (rst_i)
        sensor_shutdown_ff |=> $stable(temp_ff) && $stable(crit_st_ff) && $stable(hi_st_ff);
    endproperty
    a_sensor_shutdown_freeze: assert property (p_sensor_shutdown_freeze) else $error("state moved in shutdown");

    property p_pin_pol;
        @(posedge clk_i) disable iff (rst_i)
        ##1 alert_oe_n_o == ~($past(pol_ff) ^ active_ff);
    endproperty
    a_pin_pol: assert property (p_pin_pol) else $error("pin polarity wrong");

endmodule : tlc_alert_core

/* File: tlc_pkg.sv */
// package: register map, field positions and reset values of the limit/alert block
package tlc_pkg;

    // register byte addresses on the wishbone port
    localparam logic [7:0]  TLC_ADR_CFG      = 8'h00;
    localparam logic [7:0]  TLC_ADR_UPPER    = 8'h04;
    localparam logic [7:0]  TLC_ADR_LOWER    = 8'h08;
    localparam logic [7:0]  TLC_ADR_CRIT     = 8'h0C;
    localparam logic [7:0]  TLC_ADR_TEMP     = 8'h10;
    localparam logic [7:0]  TLC_ADR_RES      = 8'h14;

    // configuration field positions
    localparam int unsigned TLC_CFG_MODE     = 0;
    localparam int unsigned TLC_CFG_POL      = 1;
    localparam int unsigned TLC_CFG_CRITONLY = 2;
    localparam int unsigned TLC_CFG_OUTEN    = 3;
    localparam int unsigned TLC_CFG_STS      = 4;
    localparam int unsigned TLC_CFG_CLEAR    = 5;
    localparam int unsigned TLC_CFG_SENSOR_SHUTDOWN     = 8;
    localparam int unsigned TLC_CFG_HYS_LO   = 9;
    localparam int unsigned TLC_CFG_HYS_HI   = 10;

    // temperature reading field positions
    localparam int unsigned TLC_TMP_CRIT     = 15;
    localparam int unsigned TLC_TMP_HIGH     = 14;
    localparam int unsigned TLC_TMP_LOW      = 13;
    localparam int unsigned TLC_TMP_SIGN     = 12;

    // limits keep bits 12..2 only; bits 1..0 are fraction padding
    localparam int unsigned TLC_LIM_LSB      = 2;
    localparam int unsigned TLC_LIM_MSB      = 12;
    localparam int unsigned TLC_NUM_LIM      = 3;

    // values after reset
    localparam logic [10:0] TLC_LIM_RST      = 11'h000;
    localparam logic [12:0] TLC_TEMP_RST     = 13'h0000;
    localparam logic [1:0]  TLC_HYS_RST      = 2'h0;
    localparam logic [1:0]  TLC_RES_RST      = 2'h3;
    localparam logic [31:0] TLC_RDAT_RST     = 32'h0000_0000;

    // hysteresis selector codes and offsets in reading lsbs of 0.0625 degree
    typedef enum logic [1:0] {
        TLC_HYS_OFF = 2'h0,
        TLC_HYS_1P5 = 2'h1,
        TLC_HYS_3   = 2'h2,
        TLC_HYS_6   = 2'h3
    } tlc_hys_t;
    localparam logic [13:0] TLC_HYS_CNT_1P5  = 14'h0018;
    localparam logic [13:0] TLC_HYS_CNT_3    = 14'h0030;
    localparam logic [13:0] TLC_HYS_CNT_6    = 14'h0060;

endpackage : tlc_pkg

/* File: tlc_conv_model.sv */
// file: converter model that feeds periodic samples while the block lets it run
`timescale 1ns/1ns
module tlc_conv_model
#(
    parameter int PERIOD = 8
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [12:0] temp_i,
    output logic             sample_valid_o,
    output logic      [12:0] sample_data_o
);
    int cnt_ff;

    // strobe once every PERIOD cycles, and never while the block holds us stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt_ff         <= 0;
            sample_valid_o <= 1'b0;
        end
        else
        begin
            cnt_ff         <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
            sample_valid_o <= (cnt_ff == PERIOD - 1);
        end
    end

    // data means something only beside the strobe, so it toggles otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sample_data_o <= 13'h0AAA;
        else if (run_i && cnt_ff == PERIOD - 1)
            sample_data_o <= temp_i;
        else
            sample_data_o <= ~sample_data_o;
    end
endmodule : tlc_conv_model

/* File: tb.sv */
// file: self-checking bench for the limit compare and alert block
`timescale 1ns/1ns
module tb
    import tlc_pkg::*;
;
    localparam logic [15:0] INTR = 16'h1 << TLC_CFG_MODE;
    localparam logic [15:0] POL  = 16'h1 << TLC_CFG_POL;
    localparam logic [15:0] CRIT = 16'h1 << TLC_CFG_CRITONLY;
    localparam logic [15:0] EN   = 16'h1 << TLC_CFG_OUTEN;
    localparam logic [15:0] CLR  = 16'h1 << TLC_CFG_CLEAR;
    localparam logic [15:0] SENSOR_SHUTDOWN = 16'h1 << TLC_CFG_SENSOR_SHUTDOWN;

    logic        clk;
    logic        rst;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic [31:0] dat_o;
    logic        ack;
    logic        svalid;
    logic [12:0] sdata;
    logic [12:0] temp;
    logic        run;
    logic        alert;
    logic        oe_n;
    int          num_errors;
    int          tests_run;
    // open-drain pin with its pull-up
    wire         pin = oe_n ? 1'b1 : alert;

    tlc_alert_core dut_u (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .sample_valid_i(svalid), .sample_data_i(sdata),
        .conv_run_o(run), .alert_o(alert), .alert_oe_n_o(oe_n));
    tlc_conv_model conv_u (.clk_i(clk), .rst_i(rst), .run_i(run), .temp_i(temp),
        .sample_valid_o(svalid), .sample_data_o(sdata));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        adr  <= a;
        we   <= w;
        wdat <= {16'h0000, d};
        sel  <= s;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50)
            num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, 4'h3, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
        logic [31:0] q;
        wb(a, 1'b0, 16'h0000, 4'h3, q);
        chk(what, q, {16'h0000, e});
    endtask : rd

    // several sample periods so the new value has passed the pipeline
    task automatic settle(input logic [12:0] t);
        temp <= t;
        repeat (24) @(posedge clk);
    endtask : settle

    task automatic pin_is(input logic e);
        repeat (3) @(posedge clk);
        chk("pin", pin, e);
    endtask : pin_is

    task automatic t_reset();
        rd(TLC_ADR_CFG, 16'h0000, "cfg");
        rd(TLC_ADR_CRIT, 16'h0000, "crit");
        rd(TLC_ADR_TEMP, 16'h8000, "temp at zero");
        rd(TLC_ADR_RES, 16'h0003, "res");
        rd(8'h18, 16'h0000, "unmapped");
        chk("run", run, 1'b1);
        pin_is(1'b1);
    endtask : t_reset

    task automatic t_format();
        logic [31:0] q;
        wr(TLC_ADR_TEMP, 16'h1234);
        rd(TLC_ADR_TEMP, 16'h8000, "temp ro");
        wr(TLC_ADR_UPPER, 16'hFFFF);
        rd(TLC_ADR_UPPER, 16'h1FFC, "upper all");
        wb(TLC_ADR_UPPER, 1'b1, 16'h0000, 4'h1, q);
        rd(TLC_ADR_UPPER, 16'h1F00, "upper lane");
        wr(TLC_ADR_UPPER, 16'h0190);
        wr(TLC_ADR_LOWER, 16'hFE73);
        rd(TLC_ADR_LOWER, 16'h1E70, "lower neg");
        wr(TLC_ADR_CRIT, 16'h0500);
    endtask : t_format

    task automatic t_comp();
        wr(TLC_ADR_CFG, EN);
        settle(13'h01A0);
        pin_is(1'b0);
        rd(TLC_ADR_TEMP, 16'h41A0, "above high");
        wr(TLC_ADR_CFG, EN | CLR);
        pin_is(1'b0);
        settle(13'h0190);
        rd(TLC_ADR_TEMP, 16'h0190, "equal high");
        pin_is(1'b1);
        settle(13'h1E00);
        rd(TLC_ADR_TEMP, 16'h3E00, "below low");
        pin_is(1'b0);
        settle(13'h1E70);
        rd(TLC_ADR_TEMP, 16'h1E70, "equal low");
        settle(13'h0500);
        rd(TLC_ADR_TEMP, 16'hC500, "equal crit");
        settle(13'h0100);
        pin_is(1'b1);
        wr(TLC_ADR_UPPER, 16'h00F0);
        pin_is(1'b0);
        wr(TLC_ADR_UPPER, 16'h0190);
        pin_is(1'b1);
    endtask : t_comp

    task automatic t_modes();
        wr(TLC_ADR_CFG, EN | POL);
        settle(13'h01A0);
        pin_is(1'b1);
        settle(13'h0100);
        pin_is(1'b0);
        wr(TLC_ADR_CFG, EN | CRIT);
        settle(13'h01A0);
        pin_is(1'b1);
        settle(13'h0600);
        pin_is(1'b0);
        settle(13'h0100);
        pin_is(1'b1);
    endtask : t_modes

    task automatic t_intr();
        wr(TLC_ADR_CFG, EN | INTR);
        settle(13'h01A0);
        pin_is(1'b0);
        settle(13'h0180);
        pin_is(1'b0);
        wr(TLC_ADR_CFG, EN | INTR | CLR);
        pin_is(1'b1);
        rd(TLC_ADR_CFG, EN | INTR, "clear self");
        settle(13'h0600);
        pin_is(1'b0);
        wr(TLC_ADR_CFG, EN | INTR | CLR);
        pin_is(1'b0);
        settle(13'h0300);
        pin_is(1'b1);
        settle(13'h0100);
        wr(TLC_ADR_CFG, EN);
    endtask : t_intr

    task automatic t_hys();
        logic [12:0] off [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
        for (int h = 0; h < 4; h++)
        begin
            wr(TLC_ADR_CFG, EN | (16'(h) << TLC_CFG_HYS_LO));
            settle(13'h01A0);
            pin_is(1'b0);
            settle(13'h0191 - off[h]);
            pin_is(1'b0);
            settle(13'h0190 - off[h]);
            pin_is(1'b1);
        end
        wr(TLC_ADR_CFG, EN);
    endtask : t_hys

    task automatic t_res();
        settle(13'h000F);
        for (int r = 0; r < 4; r++)
        begin
            wr(TLC_ADR_RES, 16'(r));
            rd(TLC_ADR_TEMP, 16'h000F & ~((16'h1 << (3 - r)) - 16'h1), "masked");
        end
    endtask : t_res

    // shutdown freezes the pin, then the host releases the line itself
    task automatic t_sensor_shutdown();
        settle(13'h01A0);
        wr(TLC_ADR_CFG, EN | SENSOR_SHUTDOWN);
        @(posedge clk);
        chk("run", run, 1'b0);
        settle(13'h0100);
        pin_is(1'b0);
        rd(TLC_ADR_CFG, EN | SENSOR_SHUTDOWN | (16'h1 << TLC_CFG_STS), "status frozen");
        rd(TLC_ADR_TEMP, 16'h41A0, "frozen");
        wr(TLC_ADR_CFG, SENSOR_SHUTDOWN);
        pin_is(1'b1);
        wr(TLC_ADR_CFG, EN);
        settle(13'h0100);
        rd(TLC_ADR_TEMP, 16'h0100, "resumed");
        pin_is(1'b1);
    endtask : t_sensor_shutdown

    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // free-running clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // a hung handshake ends here instead of running forever
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end

    // main sequence
    initial
    begin
        rst        = 1'b1;
        cyc        = 1'b0;
        stb        = 1'b0;
        we         = 1'b0;
        adr        = 8'h00;
        wdat       = 32'h0000_0000;
        sel        = 4'h0;
        temp       = 13'h0000;
        num_errors = 0;
        tests_run  = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_format();
        t_comp();
        t_modes();
        t_intr();
        t_hys();
        t_res();
        t_sensor_shutdown();
        close_out();
    end
endmodule : tb
